//--- adc_port_pkg.sv
// shared constants for the converter result output port
// assumes one core clock domain and an axi4-lite register bus
package adc_port_pkg;
  // register byte addresses
  localparam logic [3:0] CTRL_ADDR = 4'h0;
  localparam logic [3:0] STATUS_ADDR = 4'h4;
  localparam logic [3:0] RESULT_ADDR = 4'h8;
  // ctrl fields
  localparam int CTRL_START_BIT = 0;
  // status fields
  localparam int STATUS_PHASE_LSB = 0;
  localparam int STATUS_MODE_BIT = 2;
  localparam int STATUS_PEND_BIT = 3;
  localparam int STATUS_HS_BUSY_BIT = 4;
  localparam int STATUS_RUN_BIT = 5;
  // result fields
  localparam int RESULT_SIGN_BIT = 16;
  localparam int RESULT_OVER_BIT = 17;
  // reset values and response codes
  localparam logic [31:0] RESULT_RST = 32'h0000_0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // result width in bits and timing counts, in clock counts
  localparam int RES_BITS_DEF = 16;
  localparam int INT_COUNTS_DEF = 65536;
  localparam int AZ_COUNTS_DEF = 65536;
  localparam int AZ_STOP_COUNTS = 7;
  // input synchroniser reset image: {hb,mb,lb,ce,comp,send,run,mode}
  localparam logic [7:0] SYNC_RST = 8'hF0;
  // conversion phases, gray along the cycle
  typedef enum logic [1:0] {
    PH_AUTOZERO = 2'h0,
    PH_INTEGRATE = 2'h1,
    PH_DEINTEGRATE = 2'h3,
    PH_LATCH = 2'h2
  } phase_e;
  // handshake byte transfer states
  typedef enum logic [2:0] {
    HS_IDLE = 3'h0,
    HS_WAIT = 3'h1,
    HS_FLAG = 3'h3,
    HS_LOAD = 3'h2,
    HS_REL = 3'h6
  } hs_e;
  localparam logic [1:0] GRP_LOW = 2'h0;
  localparam logic [1:0] GRP_MID = 2'h1;
  localparam logic [1:0] GRP_HIGH = 2'h2;
endpackage : adc_port_pkg

//--- sync_2ff.sv
// two flip-flop synchroniser for a vector of pin levels
// assumes each bit is an independent level from outside the clock domain
`timescale 1ns/1ps
module sync_2ff #(
  parameter int W = 8,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);
  logic [W-1:0] meta_ff;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta_ff <= RST_VAL;
      q_out <= RST_VAL;
    end else begin
      meta_ff <= d_in;
      q_out <= meta_ff;
    end
  end
endmodule : sync_2ff

//--- adc_result_byte_output_port.sv
// digital result port of a two-chip integrating converter
// assumes pins are outside the clock domain; software uses axi4-lite
`timescale 1ns/1ps
// Summary of operation
// - phase flag high integrate through deintegrate
// - sign output high for positive input
// - overrange output beside the result
// - data bits active high three-state
// - straight binary, 16 or 14 bits
// - outputs hold last completed conversion
// - low select with gate drives bits 1-8
// - handshake mode: low select becomes flag
// - 16-bit: mid select drives bits 9-16
// - 14-bit: high select drives 9-14, sign, overrange
// - 16-bit: high select drives sign, overrange
// - single on request or free running
// - sign true even at zero count
// - direct mode: gate high disables outputs
// - handshake mode: gate pin is load strobe
// - hold stops auto-zero seven counts early
module adc_result_byte_output_port #(
  parameter int RES_BITS = adc_port_pkg::RES_BITS_DEF,
  parameter int INT_COUNTS = adc_port_pkg::INT_COUNTS_DEF,
  parameter int AZ_COUNTS = adc_port_pkg::AZ_COUNTS_DEF
) (
  input wire logic core_clk_in,
  input wire logic rstn_in,
  input wire logic mode_in,
  input wire logic run_hold_in,
  input wire logic send_permit_in,
  input wire logic comp_in,
  input wire logic output_gate_strobe_in,
  output logic output_gate_strobe_out,
  output logic output_gate_strobe_oe_n_out,
  input wire logic low_byte_select_in,
  output logic low_byte_select_out,
  output logic low_byte_select_oe_n_out,
  input wire logic mid_byte_select_in,
  output logic mid_byte_select_out,
  output logic mid_byte_select_oe_n_out,
  input wire logic high_byte_select_in,
  output logic high_byte_select_out,
  output logic high_byte_select_oe_n_out,
  output logic conversion_phase_flag_out,
  output logic [RES_BITS-1:0] data_out,
  output logic [RES_BITS-1:0] data_oe_n_out,
  output logic sign_out,
  output logic sign_oe_n_out,
  output logic over_out,
  output logic over_oe_n_out,
  input wire logic [3:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [3:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in
);
  localparam int CNT_W = 18;
  localparam logic [CNT_W-1:0] AZ_LAST = CNT_W'(AZ_COUNTS - 1);
  localparam logic [CNT_W-1:0] AZ_HOLD = CNT_W'(AZ_COUNTS - adc_port_pkg::AZ_STOP_COUNTS);
  localparam logic [CNT_W-1:0] INT_LAST = CNT_W'(INT_COUNTS - 1);
  localparam logic [CNT_W-1:0] FULL_LAST = CNT_W'((1 << RES_BITS) - 1);
  localparam bit WIDE = (RES_BITS > 14);

  // reset release
  logic rst_meta_ff;
  logic rst_n;
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rst_meta_ff <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_n <= rst_meta_ff;
    end
  end

  // pin synchronisers
  logic [7:0] pins_s;
  sync_2ff #(.W(8), .RST_VAL(adc_port_pkg::SYNC_RST)) u_sync (
    .clk_in(core_clk_in),
    .rst_n_in(rst_n),
    .d_in({high_byte_select_in, mid_byte_select_in, low_byte_select_in, output_gate_strobe_in,
           comp_in, send_permit_in, run_hold_in, mode_in}),
    .q_out(pins_s)
  );
  logic mode_s, run_s, send_s, comp_s, gate_s, lb_s, mb_s, hb_s;
  assign {hb_s, mb_s, lb_s, gate_s, comp_s, send_s, run_s, mode_s} = pins_s;

  // conversion sequencer
  adc_port_pkg::phase_e phase_ff;
  logic [CNT_W-1:0] cnt_ff;
  logic sign_cap_ff;
  logic start_pend_ff;
  logic [RES_BITS-1:0] result_ff;
  logic sign_ff;
  logic over_ff;
  logic latch_ok_ff;
  logic start_wr;
  logic leave_az;
  logic az_parked;

  assign az_parked = (cnt_ff == AZ_HOLD) && !run_s && !start_pend_ff;
  assign leave_az = (phase_ff == adc_port_pkg::PH_AUTOZERO) && (cnt_ff == AZ_LAST);

  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      phase_ff <= adc_port_pkg::PH_AUTOZERO;
      cnt_ff <= '0;
      sign_cap_ff <= 1'b0;
      latch_ok_ff <= 1'b0;
    end else begin
      latch_ok_ff <= 1'b0;
      case (phase_ff)
        adc_port_pkg::PH_AUTOZERO: begin
          if (leave_az) begin
            phase_ff <= adc_port_pkg::PH_INTEGRATE;
            cnt_ff <= '0;
          end else if (!az_parked) begin
            cnt_ff <= cnt_ff + 1'b1;
          end
        end
        adc_port_pkg::PH_INTEGRATE: begin
          if (cnt_ff == INT_LAST) begin
            sign_cap_ff <= comp_s;
            phase_ff <= adc_port_pkg::PH_DEINTEGRATE;
            cnt_ff <= '0;
          end else begin
            cnt_ff <= cnt_ff + 1'b1;
          end
        end
        adc_port_pkg::PH_DEINTEGRATE: begin
          if ((comp_s != sign_cap_ff) || (cnt_ff == FULL_LAST)) begin
            latch_ok_ff <= (comp_s != sign_cap_ff);
            phase_ff <= adc_port_pkg::PH_LATCH;
          end else begin
            cnt_ff <= cnt_ff + 1'b1;
          end
        end
        adc_port_pkg::PH_LATCH: begin
          phase_ff <= adc_port_pkg::PH_AUTOZERO;
          cnt_ff <= '0;
        end
        default: begin
          phase_ff <= adc_port_pkg::PH_AUTOZERO;
          cnt_ff <= '0;
        end
      endcase
    end
  end

  // result latch, only updated at end of conversion
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      result_ff <= '0;
      sign_ff <= 1'b0;
      over_ff <= 1'b0;
    end else if (phase_ff == adc_port_pkg::PH_LATCH) begin
      result_ff <= cnt_ff[RES_BITS-1:0];
      sign_ff <= sign_cap_ff;
      over_ff <= !latch_ok_ff;
    end
  end

  // single conversion request; a new request wins over the clear
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      start_pend_ff <= 1'b0;
    end else if (start_wr) begin
      start_pend_ff <= 1'b1;
    end else if (leave_az) begin
      start_pend_ff <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      conversion_phase_flag_out <= 1'b0;
    end else begin
      conversion_phase_flag_out <= (phase_ff == adc_port_pkg::PH_INTEGRATE) ||
                                   (phase_ff == adc_port_pkg::PH_DEINTEGRATE);
    end
  end

  // handshake byte transfer
  adc_port_pkg::hs_e hs_ff;
  logic [1:0] grp_ff;
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      hs_ff <= adc_port_pkg::HS_IDLE;
      grp_ff <= adc_port_pkg::GRP_LOW;
    end else if (!mode_s) begin
      hs_ff <= adc_port_pkg::HS_IDLE;
    end else begin
      case (hs_ff)
        adc_port_pkg::HS_IDLE: begin
          if (phase_ff == adc_port_pkg::PH_LATCH) begin
            hs_ff <= adc_port_pkg::HS_WAIT;
            grp_ff <= adc_port_pkg::GRP_LOW;
          end
        end
        adc_port_pkg::HS_WAIT: begin
          if (send_s) begin
            hs_ff <= adc_port_pkg::HS_FLAG;
          end
        end
        adc_port_pkg::HS_FLAG: begin
          hs_ff <= adc_port_pkg::HS_LOAD;
        end
        adc_port_pkg::HS_LOAD: begin
          hs_ff <= adc_port_pkg::HS_REL;
        end
        adc_port_pkg::HS_REL: begin
          if (grp_ff == adc_port_pkg::GRP_HIGH) begin
            hs_ff <= adc_port_pkg::HS_IDLE;
          end else begin
            hs_ff <= adc_port_pkg::HS_WAIT;
            grp_ff <= (WIDE && grp_ff == adc_port_pkg::GRP_LOW) ? adc_port_pkg::GRP_MID : adc_port_pkg::GRP_HIGH;
          end
        end
        default: begin
          hs_ff <= adc_port_pkg::HS_IDLE;
        end
      endcase
    end
  end

  // byte group enables
  logic hs_present;
  logic [2:0] grp_en;
  assign hs_present = (hs_ff == adc_port_pkg::HS_FLAG) || (hs_ff == adc_port_pkg::HS_LOAD);
  always_comb begin
    if (!mode_s) begin
      grp_en[0] = !gate_s && !lb_s;
      grp_en[1] = WIDE && !gate_s && !mb_s;
      grp_en[2] = !gate_s && !hb_s;
    end else begin
      grp_en[0] = hs_present && (grp_ff == adc_port_pkg::GRP_LOW);
      grp_en[1] = hs_present && (grp_ff == adc_port_pkg::GRP_MID);
      grp_en[2] = hs_present && (grp_ff == adc_port_pkg::GRP_HIGH);
    end
  end

  // data pins, one enable per bit
  genvar gi;
  generate
    for (gi = 0; gi < RES_BITS; gi++) begin : g_bit
      always_ff @(posedge core_clk_in or negedge rst_n) begin
        if (!rst_n) begin
          data_out[gi] <= 1'b0;
          data_oe_n_out[gi] <= 1'b1;
        end else begin
          data_out[gi] <= result_ff[gi];
          if (gi < 8) begin
            data_oe_n_out[gi] <= !grp_en[0];
          end else begin
            data_oe_n_out[gi] <= WIDE ? !grp_en[1] : !grp_en[2];
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      sign_out <= 1'b0;
      sign_oe_n_out <= 1'b1;
      over_out <= 1'b0;
      over_oe_n_out <= 1'b1;
    end else begin
      sign_out <= sign_ff;
      over_out <= over_ff;
      sign_oe_n_out <= !grp_en[2];
      over_oe_n_out <= !grp_en[2];
    end
  end

  // select and gate pins: inputs in direct mode, flags and strobe in handshake mode (14-bit: mid select stays input)
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      low_byte_select_out <= 1'b1;
      low_byte_select_oe_n_out <= 1'b1;
      mid_byte_select_out <= 1'b1;
      mid_byte_select_oe_n_out <= 1'b1;
      high_byte_select_out <= 1'b1;
      high_byte_select_oe_n_out <= 1'b1;
      output_gate_strobe_out <= 1'b1;
      output_gate_strobe_oe_n_out <= 1'b1;
    end else begin
      low_byte_select_oe_n_out <= !mode_s;
      mid_byte_select_oe_n_out <= !(mode_s && WIDE);
      high_byte_select_oe_n_out <= !mode_s;
      output_gate_strobe_oe_n_out <= !mode_s;
      low_byte_select_out <= !grp_en[0];
      mid_byte_select_out <= !grp_en[1];
      high_byte_select_out <= !grp_en[2];
      output_gate_strobe_out <= !(mode_s && hs_ff == adc_port_pkg::HS_LOAD);
    end
  end

  // axi4-lite write channel
  logic [3:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic do_write;
  assign do_write = !s_axi_awready_out && !s_axi_wready_out && !s_axi_bvalid_out;
  assign start_wr = do_write && (awaddr_ff == adc_port_pkg::CTRL_ADDR) && wstrb_ff[0] &&
                    wdata_ff[adc_port_pkg::CTRL_START_BIT];
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_awready_out <= 1'b1;
      s_axi_wready_out <= 1'b1;
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out <= adc_port_pkg::RESP_OKAY;
      awaddr_ff <= '0;
      wdata_ff <= '0;
      wstrb_ff <= '0;
    end else begin
      if (s_axi_awvalid_in && s_axi_awready_out) begin
        s_axi_awready_out <= 1'b0;
        awaddr_ff <= s_axi_awaddr_in;
      end
      if (s_axi_wvalid_in && s_axi_wready_out) begin
        s_axi_wready_out <= 1'b0;
        wdata_ff <= s_axi_wdata_in;
        wstrb_ff <= s_axi_wstrb_in;
      end
      if (do_write) begin
        s_axi_bvalid_out <= 1'b1;
        s_axi_bresp_out <= (awaddr_ff == adc_port_pkg::CTRL_ADDR) ? adc_port_pkg::RESP_OKAY :
                           adc_port_pkg::RESP_SLVERR;
      end
      if (s_axi_bvalid_out && s_axi_bready_in) begin
        s_axi_bvalid_out <= 1'b0;
        s_axi_awready_out <= 1'b1;
        s_axi_wready_out <= 1'b1;
      end
    end
  end

  // axi4-lite read channel
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready_out <= 1'b1;
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out <= '0;
      s_axi_rresp_out <= adc_port_pkg::RESP_OKAY;
    end else if (s_axi_arvalid_in && s_axi_arready_out) begin
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out <= 1'b1;
      s_axi_rresp_out <= adc_port_pkg::RESP_OKAY;
      s_axi_rdata_out <= '0;
      case (s_axi_araddr_in)
        adc_port_pkg::CTRL_ADDR: begin
          s_axi_rdata_out <= '0;
        end
        adc_port_pkg::STATUS_ADDR: begin
          s_axi_rdata_out[adc_port_pkg::STATUS_PHASE_LSB +: 2] <= phase_ff;
          s_axi_rdata_out[adc_port_pkg::STATUS_MODE_BIT] <= mode_s;
          s_axi_rdata_out[adc_port_pkg::STATUS_PEND_BIT] <= start_pend_ff;
          s_axi_rdata_out[adc_port_pkg::STATUS_HS_BUSY_BIT] <= (hs_ff != adc_port_pkg::HS_IDLE);
          s_axi_rdata_out[adc_port_pkg::STATUS_RUN_BIT] <= run_s;
        end
        adc_port_pkg::RESULT_ADDR: begin
          s_axi_rdata_out[RES_BITS-1:0] <= result_ff;
          s_axi_rdata_out[adc_port_pkg::RESULT_SIGN_BIT] <= sign_ff;
          s_axi_rdata_out[adc_port_pkg::RESULT_OVER_BIT] <= over_ff;
        end
        default: begin
          s_axi_rresp_out <= adc_port_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid_out && s_axi_rready_in) begin
      s_axi_rvalid_out <= 1'b0;
      s_axi_arready_out <= 1'b1;
    end
  end

  // checks
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n);

  a_flag_in_az: assert property ((phase_ff == adc_port_pkg::PH_AUTOZERO) [*2] |-> !conversion_phase_flag_out)
    else $error("phase flag high during auto-zero");
  a_flag_deint: assert property ((phase_ff == adc_port_pkg::PH_DEINTEGRATE) |=> conversion_phase_flag_out)
    else $error("phase flag low during deintegrate");
  a_result_hold: assert property ((phase_ff != adc_port_pkg::PH_LATCH) |=> $stable(result_ff) && $stable(sign_ff))
    else $error("result changed outside latch");
  a_sign_capture: assert property ((phase_ff == adc_port_pkg::PH_LATCH) |=> sign_ff == $past(sign_cap_ff))
    else $error("sign not taken from integrate end");
  a_gate_disable: assert property (!mode_s && gate_s |=> (&data_oe_n_out) && sign_oe_n_out && over_oe_n_out)
    else $error("outputs driven with gate high");
  a_low_group: assert property (!mode_s && !gate_s && !lb_s |=> data_oe_n_out[7:0] == 8'h00)
    else $error("low byte not driven");
  a_high_group: assert property (!mode_s && !gate_s && !hb_s |=> !sign_oe_n_out && !over_oe_n_out)
    else $error("sign and overrange not driven");
  a_upper_group: assert property (!mode_s && !gate_s && !(WIDE ? mb_s : hb_s) |=> data_oe_n_out[8] == 1'b0)
    else $error("upper data group not driven");
  a_flag_output: assert property (mode_s |=> !low_byte_select_oe_n_out && !output_gate_strobe_oe_n_out)
    else $error("select pin not output in handshake mode");
  a_load_strobe: assert property (mode_s && hs_ff == adc_port_pkg::HS_FLAG |=> ##1 !output_gate_strobe_out)
    else $error("load strobe missing");
  a_hold_park: assert property ((phase_ff == adc_port_pkg::PH_AUTOZERO) && az_parked && !start_wr |=> cnt_ff == AZ_HOLD)
    else $error("hold did not park in auto-zero");
  a_idle_hiz: assert property (mode_s && hs_ff == adc_port_pkg::HS_IDLE |=> &data_oe_n_out)
    else $error("data driven while idle");

  c_latch: cover property (phase_ff == adc_port_pkg::PH_LATCH);
  c_hs_load: cover property (hs_ff == adc_port_pkg::HS_LOAD && grp_ff == adc_port_pkg::GRP_HIGH);
  c_parked: cover property ((phase_ff == adc_port_pkg::PH_AUTOZERO && az_parked) [*3]);
endmodule : adc_result_byte_output_port

//--- afe_bus_model.sv
// analog front end and byte bus listener at the far side of the result port
// assumes active-low byte flags, a load strobe and a bus resolved by the bench
`timescale 1ns/1ps
module afe_bus_model #(
  parameter int INT_COUNTS = 32
) (
  input wire logic clk_in,
  input wire logic clr_in,
  input wire logic flag_in,
  input wire logic pos_in,
  input wire logic signed [15:0] level_in,
  input wire logic [15:0] bus_in,
  input wire logic [1:0] so_in,
  input wire logic [2:0] sel_n_in,
  input wire logic load_n_in,
  output logic comp_out,
  output logic [20:0] rec_out [3],
  output int loads_out
);
  int acc;
  int t;
  // integrate, hold a few counts, then run down toward zero
  always_ff @(posedge clk_in) begin
    if (!flag_in) begin
      acc <= 0;
      t <= 0;
    end else begin
      t <= t + 1;
      if (t < INT_COUNTS) begin
        acc <= acc + int'(level_in);
      end else if (t >= INT_COUNTS + 4) begin
        acc <= pos_in ? acc - 1 : acc + 1;
      end
    end
  end
  // a zero level still shows its true polarity
  assign comp_out = (acc > 0) || (acc == 0 && pos_in);
  // one byte record taken on each of the first three load strobe cycles
  always_ff @(posedge clk_in) begin
    if (clr_in) begin
      loads_out <= 0;
    end else if (!load_n_in) begin
      if (loads_out < 3) begin
        rec_out[loads_out] <= {sel_n_in, so_in, bus_in};
      end
      loads_out <= loads_out + 1;
    end
  end
endmodule : afe_bus_model

//--- testbench.sv
// self-checking bench for the converter result port with a 16-bit result
// assumes short conversion counts and pull-ups on the enable pins
`timescale 1ns/1ps
module testbench;
  logic clk, rstn, mode, run, send, gate_d, clr, pos;
  logic [2:0] sel_d;
  logic signed [15:0] lvl;
  logic [3:0] awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata, res;
  logic awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic gate_o, gate_oe_n, l_o, l_oe_n, m_o, m_oe_n, h_o, h_oe_n, flag, sgn, sgn_oe_n, ovr, ovr_oe_n, comp;
  logic [15:0] dat, dat_oe_n, bus;
  logic [1:0] so;
  logic gate_w;
  logic [2:0] sel_w;
  logic [20:0] rec [3];
  int loads, error_cnt, n_checks;
  int cyc = 0;
  assign gate_w = gate_oe_n ? gate_d : gate_o;
  assign sel_w = {h_oe_n ? sel_d[2] : h_o, m_oe_n ? sel_d[1] : m_o, l_oe_n ? sel_d[0] : l_o};
  assign bus = dat ^ dat_oe_n;
  assign so = {sgn ^ sgn_oe_n, ovr ^ ovr_oe_n};
  adc_result_byte_output_port #(.RES_BITS(16), .INT_COUNTS(32), .AZ_COUNTS(32)) dut (
    .core_clk_in(clk), .rstn_in(rstn), .mode_in(mode), .run_hold_in(run), .send_permit_in(send),
    .comp_in(comp), .output_gate_strobe_in(gate_w), .output_gate_strobe_out(gate_o),
    .output_gate_strobe_oe_n_out(gate_oe_n), .low_byte_select_in(sel_w[0]), .low_byte_select_out(l_o),
    .low_byte_select_oe_n_out(l_oe_n), .mid_byte_select_in(sel_w[1]), .mid_byte_select_out(m_o),
    .mid_byte_select_oe_n_out(m_oe_n), .high_byte_select_in(sel_w[2]), .high_byte_select_out(h_o),
    .high_byte_select_oe_n_out(h_oe_n), .conversion_phase_flag_out(flag), .data_out(dat),
    .data_oe_n_out(dat_oe_n), .sign_out(sgn), .sign_oe_n_out(sgn_oe_n), .over_out(ovr),
    .over_oe_n_out(ovr_oe_n), .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
    .s_axi_awready_out(awready), .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb),
    .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
    .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready), .s_axi_araddr_in(araddr),
    .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
    .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready));
  afe_bus_model #(.INT_COUNTS(32)) far (
    .clk_in(clk), .clr_in(clr), .flag_in(flag), .pos_in(pos), .level_in(lvl), .bus_in(bus),
    .so_in(so), .sel_n_in(sel_w), .load_n_in(gate_w), .comp_out(comp), .rec_out(rec), .loads_out(loads));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      $display("unexpected timeout expected done seen running");
      error_cnt++;
      close_out();
    end
  end
  task automatic close_out();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : close_out
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bready && bvalid) begin
        r = bresp;
        bready <= 1'b0;
      end
    end while (awvalid || wvalid || bready);
  endtask : axi_wr
  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rready && rvalid) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
      end
    end while (arvalid || rready);
  endtask : axi_rd
  task automatic wait_flag(input logic v);
    while (flag !== v) begin
      @(posedge clk);
    end
  endtask : wait_flag
  task automatic quiet(input int n);
    int hi;
    hi = 0;
    repeat (n) begin
      @(posedge clk);
      if (flag !== 1'b0) hi++;
    end
    check("flag while parked", hi, 0);
  endtask : quiet
  task automatic t_reset();
    logic [31:0] r;
    logic [1:0] e;
    check("data enables idle", dat_oe_n, 16'hffff);
    check("sign enables idle", {sgn_oe_n, ovr_oe_n}, 2'b11);
    check("phase flag idle", flag, 1'b0);
    axi_rd(adc_port_pkg::RESULT_ADDR, r, e);
    check("result reset", r, adc_port_pkg::RESULT_RST);
    axi_rd(4'hc, r, e);
    check("unmapped read resp", e, adc_port_pkg::RESP_SLVERR);
    check("unmapped read data", r, 32'h0000_0000);
    axi_wr(adc_port_pkg::STATUS_ADDR, 32'hffff_ffff, e);
    check("status write resp", e, adc_port_pkg::RESP_SLVERR);
  endtask : t_reset
  task automatic t_conv(input logic p, input int k);
    logic [31:0] r;
    logic [1:0] e;
    wait_flag(1'b0);
    pos <= p;
    lvl <= p ? 16'(k) : -16'(k);
    wait_flag(1'b1);
    axi_rd(adc_port_pkg::STATUS_ADDR, r, e);
    check("phase in conversion", r[0], 1'b1);
    wait_flag(1'b0);
    axi_rd(adc_port_pkg::STATUS_ADDR, r, e);
    check("phase after latch", r[1:0], adc_port_pkg::PH_AUTOZERO);
    axi_rd(adc_port_pkg::RESULT_ADDR, r, e);
    res = r;
    check("sign", r[adc_port_pkg::RESULT_SIGN_BIT], p);
    check("overrange", r[adc_port_pkg::RESULT_OVER_BIT], 1'b0);
    check("count window", r[15:0] >= 32 * k && r[15:0] <= 32 * k + 12, 1'b1);
  endtask : t_conv
  task automatic t_direct();
    gate_d <= 1'b0;
    for (int g = 0; g < 3; g++) begin
      sel_d <= ~(3'b001 << g);
      repeat (4) @(posedge clk);
      check("group data enables", dat_oe_n, g == 0 ? 16'hff00 : g == 1 ? 16'h00ff : 16'hffff);
      check("group sign enables", {sgn_oe_n, ovr_oe_n}, g == 2 ? 2'b00 : 2'b11);
    end
    sel_d <= 3'b000;
    repeat (4) @(posedge clk);
    wait_flag(1'b1);
    check("bus during conversion", bus, res[15:0]);
    check("sign and overrange pins", so, {res[16], res[17]});
    gate_d <= 1'b1;
    repeat (4) @(posedge clk);
    check("gated data enables", dat_oe_n, 16'hffff);
    check("gated sign enables", {sgn_oe_n, ovr_oe_n}, 2'b11);
    sel_d <= 3'b111;
  endtask : t_direct
  task automatic t_hold();
    logic [31:0] r;
    logic [1:0] e;
    int t0;
    wait_flag(1'b1);
    run <= 1'b0;
    wait_flag(1'b0);
    quiet(300);
    axi_rd(adc_port_pkg::STATUS_ADDR, r, e);
    check("parked phase", r[1:0], adc_port_pkg::PH_AUTOZERO);
    check("run status", r[adc_port_pkg::STATUS_RUN_BIT], 1'b0);
    t0 = cyc;
    axi_wr(adc_port_pkg::CTRL_ADDR, 32'h0000_0001, e);
    check("start resp", e, adc_port_pkg::RESP_OKAY);
    wait_flag(1'b1);
    check("start delay", cyc - t0 >= 7 && cyc - t0 <= 14, 1'b1);
    wait_flag(1'b0);
    quiet(300);
    run <= 1'b1;
  endtask : t_hold
  task automatic t_hs();
    logic [31:0] r;
    logic [1:0] e;
    send <= 1'b0;
    mode <= 1'b1;
    clr <= 1'b1;
    wait_flag(1'b1);
    clr <= 1'b0;
    wait_flag(1'b0);
    repeat (20) @(posedge clk);
    check("loads while held", loads, 0);
    check("pins as outputs", {gate_oe_n, h_oe_n, m_oe_n, l_oe_n}, 4'h0);
    axi_rd(adc_port_pkg::RESULT_ADDR, r, e);
    send <= 1'b1;
    while (loads < 3) begin
      @(posedge clk);
    end
    send <= 1'b0;
    repeat (10) @(posedge clk);
    check("load strobes", loads, 3);
    check("low flag", rec[0][20:18], 3'b110);
    check("low byte", rec[0][7:0], r[7:0]);
    check("mid flag", rec[1][20:18], 3'b101);
    check("mid byte", rec[1][15:8], r[15:8]);
    check("high flag", rec[2][20:18], 3'b011);
    check("high byte", rec[2][17:16], {r[16], r[17]});
    mode <= 1'b0;
    repeat (5) @(posedge clk);
    check("gate back to input", gate_oe_n, 1'b1);
  endtask : t_hs
  initial begin
    {mode, send, clr, awvalid, wvalid, bready, arvalid, rready} = 8'h00;
    {run, gate_d, pos} = 3'b111;
    sel_d = 3'b111;
    lvl = 16'h0003;
    awaddr = 4'h0;
    araddr = 4'h0;
    wdata = 32'h0000_0000;
    wstrb = 4'hf;
    rstn = 1'b0;
    error_cnt = 0;
    n_checks = 0;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    t_reset();
    t_conv(1'b1, 3);
    t_direct();
    t_conv(1'b1, 0);
    t_conv(1'b0, 0);
    t_conv(1'b0, 2);
    t_hold();
    t_hs();
    close_out();
  end
endmodule : testbench
